// >>> synth_divider.sv
// Contract
// - Divide input by ratio up to 1999
// - Each digit latched by its own strobe
// - AM bypasses prescaler and first decade
// - Step is 10 kHz AM, 100 kHz FM
// - FM prescaler divides by ten overall
// - Comparator corrects on phase or frequency error
// - Up to 200 AM, 2000 FM channels
// - Output idle when matched, up lead, down lag
// - Pulse width equals rising edge interval
`timescale 1ns/1ns
`default_nettype none
module synth_divider
    import synth_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic lo_i,
    input wire logic ref_i,
    input wire logic band_select_i,
    input wire logic [3:0] digit_i,
    input wire logic [3:0] strobe_i,
    output logic div_out_o,
    output logic pd_out_o,
    output logic pd_oe_n_o,
    output logic [3:0] stage_ones_o
);
    // Two-flop synchronisers for every pin input
    logic [1:0] lo_s, ref_s, band_s;
    logic [3:0] dig_s0, dig_s1, stb_s0, stb_s1;
    // Delayed copies for edge detection
    logic lo_d, ref_d;
    logic [3:0] stb_d;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            lo_s <= 2'h0;
            ref_s <= 2'h0;
            band_s <= 2'h0;
            dig_s0 <= 4'h0;
            dig_s1 <= 4'h0;
            stb_s0 <= 4'h0;
            stb_s1 <= 4'h0;
            lo_d <= 1'b0;
            ref_d <= 1'b0;
            stb_d <= 4'h0;
        end else begin
            lo_s <= {lo_s[0], lo_i};
            ref_s <= {ref_s[0], ref_i};
            band_s <= {band_s[0], band_select_i};
            dig_s0 <= digit_i;
            dig_s1 <= dig_s0;
            stb_s0 <= strobe_i;
            stb_s1 <= stb_s0;
            lo_d <= lo_s[1];
            ref_d <= ref_s[1];
            stb_d <= stb_s1;
        end
    end

    // Rising edges seen after synchronisation
    wire lo_rise = lo_s[1] & ~lo_d;
    wire ref_rise = ref_s[1] & ~ref_d;
    wire [3:0] stb_rise = stb_s1 & ~stb_d;

    // Holding latches, one per digit; thousands digit is one bit
    logic [3:0] hold_ones, hold_tens, hold_hund;
    logic hold_thou;

    // Each strobe loads only its own latch, one digit at a time
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            hold_ones <= DIGIT_RESET;
            hold_tens <= DIGIT_RESET;
            hold_hund <= DIGIT_RESET;
            hold_thou <= 1'b0;
        end else begin
            if (stb_rise[DIGIT_ONES]) begin
                hold_ones <= dig_s1;
            end
            if (stb_rise[DIGIT_TENS]) begin
                hold_tens <= dig_s1;
            end
            if (stb_rise[DIGIT_HUNDREDS]) begin
                hold_hund <= dig_s1;
            end
            if (stb_rise[DIGIT_THOUSANDS]) begin
                hold_thou <= dig_s1[0];
            end
        end
    end

    // Prescaler by five; with the external divide-by-two gives ten
    logic [2:0] pre_cnt;
    logic band_am;
    assign band_am = (band_s[1] == BAND_AM);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pre_cnt <= PRESCALE_RESET;
        end else if (band_am) begin
            pre_cnt <= PRESCALE_RESET;
        end else if (lo_rise) begin
            if (pre_cnt == PRESCALE_DIV - 3'h1) begin
                pre_cnt <= PRESCALE_RESET;
            end else begin
                pre_cnt <= pre_cnt + 3'h1;
            end
        end
    end

    // Counter clock: prescaled in FM, raw oscillator in AM
    wire cnt_tick = band_am ? lo_rise :
        (lo_rise && pre_cnt == PRESCALE_DIV - 3'h1);

    // Down counter in BCD stages; ones stage unused in AM
    logic [3:0] c_ones, c_tens, c_hund;
    logic c_thou;
    // Terminal count: all used stages at zero, ones ignored in AM
    wire ones_zero = band_am || (c_ones == DIGIT_RESET);
    wire at_term = ones_zero && c_tens == DIGIT_RESET &&
        c_hund == DIGIT_RESET && !c_thou;

    // Borrow through decades, reload latched ratio at terminal count
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            c_ones <= DIGIT_RESET;
            c_tens <= DIGIT_RESET;
            c_hund <= DIGIT_RESET;
            c_thou <= 1'b0;
        end else if (cnt_tick) begin
            if (at_term) begin
                // Reload; AM drops the ones digit so step is 10 kHz
                c_ones <= hold_ones;
                c_tens <= hold_tens;
                c_hund <= hold_hund;
                c_thou <= hold_thou;
            end else if (!ones_zero) begin
                c_ones <= c_ones - 4'h1;
            end else begin
                c_ones <= band_am ? c_ones : 4'h9;
                if (c_tens != DIGIT_RESET) begin
                    c_tens <= c_tens - 4'h1;
                end else begin
                    c_tens <= 4'h9;
                    if (c_hund != DIGIT_RESET) begin
                        c_hund <= c_hund - 4'h1;
                    end else begin
                        c_hund <= 4'h9;
                        c_thou <= 1'b0;
                    end
                end
            end
        end
    end

    // One divided pulse per completed cycle
    logic div_pulse;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            div_pulse <= 1'b0;
        end else begin
            div_pulse <= cnt_tick && at_term;
        end
    end

    // Divided output toggles each cycle so its rising edge marks every second cycle
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            div_out_o <= 1'b0;
        end else if (div_pulse) begin
            div_out_o <= ~div_out_o;
        end
    end

    // Ones stage visible for observation
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            stage_ones_o <= DIGIT_RESET;
        end else begin
            stage_ones_o <= c_ones;
        end
    end

    // Phase detector: divided edge first drives high until ref edge
    pd_state_t pd_state;
    wire div_rise = div_pulse && !div_out_o;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pd_state <= PD_IDLE;
        end else begin
            case (pd_state)
                PD_IDLE: begin
                    if (div_rise && !ref_rise) begin
                        pd_state <= PD_UP;
                    end else if (ref_rise && !div_rise) begin
                        pd_state <= PD_DOWN;
                    end
                end
                PD_UP: begin
                    if (ref_rise) begin
                        pd_state <= PD_IDLE;
                    end
                end
                PD_DOWN: begin
                    if (div_rise) begin
                        pd_state <= PD_IDLE;
                    end
                end
                default: pd_state <= PD_IDLE;
            endcase
        end
    end

    // Registered three-state drive; enable low while driving
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pd_out_o <= 1'b0;
            pd_oe_n_o <= 1'b1;
        end else begin
            pd_out_o <= (pd_state == PD_UP);
            pd_oe_n_o <= (pd_state == PD_IDLE);
        end
    end

    a_pd_idle_hiz: assert property (@(posedge clock_i) disable iff (rst_i)
        (pd_state == PD_IDLE) |=> pd_oe_n_o)
        else $error("detector drives while idle");

    a_pd_up_level: assert property (@(posedge clock_i) disable iff (rst_i)
        (pd_state == PD_UP) |=> (pd_out_o && !pd_oe_n_o))
        else $error("lead pulse not high");

    a_pd_up_end: assert property (@(posedge clock_i) disable iff (rst_i)
        (pd_state == PD_UP && ref_rise) |=> pd_state == PD_IDLE)
        else $error("lead pulse not ended by reference");

    a_pd_down_end: assert property (@(posedge clock_i) disable iff (rst_i)
        (pd_state == PD_DOWN && div_rise) |=> pd_state == PD_IDLE)
        else $error("lag pulse not ended by divider");

    a_reload_ratio: assert property (@(posedge clock_i) disable iff (rst_i)
        (cnt_tick && at_term) |=> (c_tens == $past(hold_tens) &&
        c_hund == $past(hold_hund) && c_thou == $past(hold_thou)))
        else $error("ratio not reloaded");

    a_term_pulse: assert property (@(posedge clock_i) disable iff (rst_i)
        (cnt_tick && at_term) |=> div_pulse ##1 (div_out_o != $past(div_out_o)))
        else $error("division edge missing");

    a_am_bypass: assert property (@(posedge clock_i) disable iff (rst_i)
        band_am |=> pre_cnt == PRESCALE_RESET)
        else $error("prescaler active in AM");

    a_strobe_load: assert property (@(posedge clock_i) disable iff (rst_i)
        stb_rise[DIGIT_TENS] |=> hold_tens == $past(dig_s1))
        else $error("digit not latched");

    a_no_midload: assert property (@(posedge clock_i) disable iff (rst_i)
        (!(cnt_tick && at_term) && stb_rise[DIGIT_HUNDREDS] && c_hund != 4'h0
        && !cnt_tick) |=> c_hund == $past(c_hund))
        else $error("digit applied mid cycle");

    a_prescale_max: assert property (@(posedge clock_i) disable iff (rst_i)
        pre_cnt < PRESCALE_DIV)
        else $error("prescaler out of range");
endmodule
`default_nettype wire

// >>> synth_pkg.sv
package synth_pkg;
    // Digit positions of the division ratio
    localparam int unsigned DIGIT_COUNT = 4;
    localparam logic [1:0] DIGIT_ONES = 2'h0;
    localparam logic [1:0] DIGIT_TENS = 2'h1;
    localparam logic [1:0] DIGIT_HUNDREDS = 2'h2;
    localparam logic [1:0] DIGIT_THOUSANDS = 2'h3;
    // Largest programmable ratio
    localparam logic [10:0] RATIO_MAX = 11'h7cf;
    // On-chip prescaler divides by five
    localparam logic [2:0] PRESCALE_DIV = 3'h5;
    localparam logic [2:0] PRESCALE_RESET = 3'h0;
    // Counter reset value, BCD
    localparam logic [3:0] DIGIT_RESET = 4'h0;
    // Band select encoding
    localparam logic BAND_FM = 1'b0;
    localparam logic BAND_AM = 1'b1;
    // Phase detector states
    typedef enum logic [1:0] {
        PD_IDLE = 2'b00,
        PD_UP = 2'b01,
        PD_DOWN = 2'b10
    } pd_state_t;
endpackage

// >>> tune_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// Tuning controller: loads four BCD digits, one strobe per digit
module tune_ctrl_model (
    input wire logic clock_i,
    input wire logic start_i,
    input wire logic [15:0] bcd_i,
    output logic [3:0] digit_o,
    output logic [3:0] strobe_o,
    output logic done_o
);
    initial begin
        digit_o = 4'h0;
        strobe_o = 4'h0;
        done_o = 1'b0;
    end
    // Each load walks the digits ones first, holding data around the strobe
    always begin
        @(posedge clock_i);
        if (start_i === 1'b1) begin
            for (int d = 0; d < 4; d++) begin
                digit_o <= bcd_i[4*d +: 4];
                repeat (4) @(posedge clock_i);
                strobe_o[d] <= 1'b1;
                repeat (4) @(posedge clock_i);
                strobe_o[d] <= 1'b0;
                repeat (4) @(posedge clock_i);
            end
            // Bus no longer valid once the load is over
            digit_o <= ~digit_o;
            done_o <= 1'b1;
            @(posedge clock_i);
            done_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> test_pll_synth_programmable_divider.sv
`timescale 1ns/1ns
`default_nettype none
module test_pll_synth_programmable_divider;
    import synth_pkg::*;
    logic clock_i = 1'b0; // System clock
    logic rst_i = 1'b1; // Reset, held at start
    logic lo_i = 1'b0; // Oscillator, eight clocks per period
    logic ref_i = 1'b0; // Reference pin
    logic band_select_i = BAND_FM;
    logic start = 1'b0;
    logic [15:0] bcd = 16'h0000;
    logic [3:0] digit;
    logic [3:0] strobe;
    logic done;
    logic div_out_o;
    logic pd_out_o;
    logic pd_oe_n_o;
    logic [3:0] stage_ones;
    logic [2:0] lo_cnt = 3'h0;
    int failures = 0;
    int tests_run = 0;
    int seed = 32'h5521;
    int n;
    always #25 clock_i = ~clock_i;
    // Oscillator made from a free counter
    always @(posedge clock_i) begin
        lo_cnt <= lo_cnt + 3'h1;
        lo_i <= lo_cnt[2];
    end
    synth_divider dut_u (.clock_i(clock_i), .rst_i(rst_i), .lo_i(lo_i), .ref_i(ref_i),
        .band_select_i(band_select_i), .digit_i(digit), .strobe_i(strobe),
        .div_out_o(div_out_o), .pd_out_o(pd_out_o), .pd_oe_n_o(pd_oe_n_o),
        .stage_ones_o(stage_ones));
    tune_ctrl_model ctrl_u (.clock_i(clock_i), .start_i(start), .bcd_i(bcd),
        .digit_o(digit), .strobe_o(strobe), .done_o(done));
    // Compare and count
    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Clocks until the next rise of the divided output, bounded
    task wait_rise(output int c);
        c = 0;
        while (div_out_o !== 1'b0 && c < 20000) begin
            @(negedge clock_i);
            c++;
        end
        while (div_out_o !== 1'b1 && c < 20000) begin
            @(negedge clock_i);
            c++;
        end
        if (c >= 20000) check(32'h0, 32'h1);
    endtask
    // Expected rise-to-rise span: two division cycles of N+1 ticks
    function automatic int exp_period(input logic band, input logic [15:0] b);
        int r;
        if (band == BAND_AM) r = b[12] * 100 + b[11:8] * 10 + b[7:4];
        else r = b[12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0];
        return (band == BAND_AM) ? 2 * (r + 1) * 8 : 2 * (r + 1) * 5 * 8;
    endfunction
    // Load a ratio, let it reach a reload, then measure one period
    task run(input logic band, input logic [15:0] b);
        int c;
        // Leaving AM, a count of up to 1999 FM ticks may remain: clear it by reset
        if (band == BAND_FM && band_select_i == BAND_AM) begin
            @(posedge clock_i);
            rst_i <= 1'b1;
            @(negedge clock_i);
            check({pd_oe_n_o, pd_out_o, div_out_o, stage_ones}, 7'h40);
            @(posedge clock_i);
            rst_i <= 1'b0;
        end
        @(posedge clock_i);
        band_select_i <= band;
        bcd <= b;
        start <= 1'b1;
        @(posedge clock_i);
        start <= 1'b0;
        c = 0;
        while (done !== 1'b1 && c < 1000) begin
            @(negedge clock_i);
            c++;
        end
        if (c >= 1000) check(32'h0, 32'h1);
        repeat (3) wait_rise(c);
        wait_rise(c);
        check(c, exp_period(band, b));
    endtask
    // Watchdog
    initial begin
        repeat (80000) @(posedge clock_i);
        check(32'h0, 32'h1);
        end_sim();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge clock_i);
        @(negedge clock_i);
        check({pd_oe_n_o, pd_out_o, div_out_o}, 3'h4);
        @(posedge clock_i);
        rst_i <= 1'b0;
        run(BAND_FM, 16'h0000);
        check(stage_ones, 4'h0);
        run(BAND_AM, 16'h1999);
        // First decade is bypassed in AM, so the ones stage stands still
        n = stage_ones;
        repeat (40) @(negedge clock_i);
        check(stage_ones, n);
        // Divided edge first, no reference: pushes up
        wait_rise(n);
        repeat (4) @(negedge clock_i);
        check({pd_oe_n_o, pd_out_o}, 2'h1);
        @(posedge clock_i);
        ref_i <= 1'b1;
        repeat (6) @(negedge clock_i);
        check(pd_oe_n_o, 1'b1);
        @(posedge clock_i);
        ref_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        ref_i <= 1'b1;
        repeat (6) @(negedge clock_i);
        check({pd_oe_n_o, pd_out_o}, 2'h0);
        wait_rise(n);
        repeat (4) @(negedge clock_i);
        check(pd_oe_n_o, 1'b1);
        // AM first, so a hundreds strobe lands while a long count is running
        for (int i = 0; i < 2; i++) begin
            run(BAND_AM, {3'h0, 1'({$random(seed)} % 2), 4'({$random(seed)} % 10),
                4'({$random(seed)} % 10), 4'({$random(seed)} % 10)});
            run(BAND_FM, {8'h00, 4'({$random(seed)} % 2), 4'({$random(seed)} % 10)});
        end
        end_sim();
    end
endmodule
`default_nettype wire
